// >>> logic/homing_ctrl.sv
// Homing-mode controlword decode and statusword build.
// Assumes a process-data update strobe from the fieldbus core and
// motion engine handshakes on the same clock; stop pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "homing_defines.svh"
// Overview of operation
// - On homing completion, preset current position to the home offset.
// - Halt bit 8 set stops motion using the halt option; clear allows it.
// - Homing starts only on a 0-to-1 edge of controlword bit 4.
// - Clearing bit 4 during homing decelerates the motor to stop.
// - Start ignored if moving, halted, stop active, not enabled, or unexcited.
// - Status bit 15 follows the torque-limit-reached condition.
// - Status bit 11 is set while any internal limit is active.
// - Homing state reported jointly on status bits 13, 12 and 10.
// - Codes 000 running, 001 idle, 011 done, 101 alarm abort.
// - Status bit 9 rises once initialization is finished.
// - Status bit 7 follows the information condition with no acknowledge.
// - Factory state uses sensor-held fixed parameters first.
// - Sensor-held parameters are fixed; overwrite attempts are rejected.
// - After priority setup, driver parameters govern homing.
// - Priority takes effect only after NV write and power cycle.
// - Method selects procedure; 17,18,24,28,35,37,-1 accepted, 35/37 preset.
module homing_ctrl
  import homing_pkg::*;
#(
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Process data
  input  wire logic        pdo_update,
  input  wire logic [15:0] cmd_word_in,
  output logic      [15:0] drive_status_word,
  output logic      [15:0] drive_command_word,
  // Object writes
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [31:0] obj_data,
  output logic             obj_reject,
  // Drive conditions
  input  wire logic        op_enabled,
  input  wire logic        motor_excited,
  input  wire logic        stop_pin,
  input  wire logic        sensor_param_wr,
  input  wire logic        torque_limit_reached,
  input  wire logic        forward_limit_sensor,
  input  wire logic        reverse_limit_sensor,
  input  wire logic        forward_motion_prohibit,
  input  wire logic        reverse_motion_prohibit,
  input  wire logic        soft_limit,
  input  wire logic        mech_limit,
  input  wire logic        info_active,
  input  wire logic        restored_priority,
  // Motion engine
  input  wire logic        motion_busy,
  input  wire logic        home_done,
  input  wire logic        home_alarm,
  output logic             home_start,
  output logic             decel_stop,
  output logic             halt_stop,
  output logic      [15:0] halt_option,
  output logic      [7:0]  home_method,
  output logic             preset_pos,
  output logic      [31:0] preset_value,
  output logic             use_driver_params,
  output logic             nv_write_req
);
  logic       stop_lvl;
  logic       m_valid;
  logic       m_preset;
  pin_sync u_stop (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (stop_pin),
    .level  (stop_lvl)
  );
  logic [15:0] cw_q, cw_d;
  logic        prev4_q, prev4_d;
  logic        homing_q, homing_d;
  home_code_t  code_q, code_d;
  logic        start_q, start_d;
  logic        decel_q, decel_d;
  logic        halt_q, halt_d;
  logic        preset_q, preset_d;
  logic [31:0] offs_q, offs_d;
  logic [15:0] hopt_q, hopt_d;
  logic [7:0]  meth_q, meth_d;
  logic [7:0]  opset_q, opset_d;
  logic        nvreq_q, nvreq_d;
  logic        nvdone_q, nvdone_d;
  logic        drvpri_q, drvpri_d;
  logic        boot_q, boot_d;
  logic        rej_q, rej_d;
  logic [15:0] sw_q, sw_d;
  logic        remote_q, remote_d;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_q, init_d;
  logic        start_edge;
  logic        blocked;
  logic        ilim;
  method_check u_meth (
    .method      (meth_q),
    .valid       (m_valid),
    .preset_only (m_preset)
  );
  always_comb begin
    cw_d     = cw_q;
    prev4_d  = prev4_q;
    homing_d = homing_q;
    code_d   = code_q;
    start_d  = 1'b0;
    preset_d = 1'b0;
    decel_d  = 1'b0;
    offs_d   = offs_q;
    hopt_d   = hopt_q;
    meth_d   = meth_q;
    opset_d  = opset_q;
    nvreq_d  = 1'b0;
    nvdone_d = nvdone_q;
    rej_d    = 1'b0;
    start_edge = 1'b0;
    blocked  = motion_busy | homing_q | cw_q[`CW_HALT_BIT] | stop_lvl
             | ~op_enabled | ~motor_excited;
    if (pdo_update) begin
      cw_d    = cmd_word_in;
      prev4_d = cw_q[`CW_START_BIT];
    end
    start_edge = cw_q[`CW_START_BIT] & ~prev4_q;
    halt_d = cw_q[`CW_HALT_BIT];
    if (homing_q) begin
      if (home_alarm) begin
        homing_d = 1'b0;
        code_d   = HS_ALARM;
      end else if (home_done) begin
        homing_d = 1'b0;
        code_d   = HS_DONE;
        preset_d = 1'b1;
      end else if (!cw_q[`CW_START_BIT] || cw_q[`CW_HALT_BIT]) begin
        homing_d = 1'b0;
        decel_d  = 1'b1;
        code_d   = HS_IDLE;
      end
    end else if (start_edge && !blocked && m_valid && pdo_update) begin
      // Preset methods finish at once: no motion, so no run is started
      if (m_preset) begin
        preset_d = 1'b1;
        code_d   = HS_DONE;
      end else begin
        start_d  = 1'b1;
        homing_d = 1'b1;
        code_d   = HS_RUNNING;
      end
    end
    if (obj_wr) begin
      if (sensor_param_wr) begin
        rej_d = 1'b1;
      end else begin
        unique case (obj_index)
          `HOME_OFFSET_INDEX: offs_d  = obj_data;
          `HALT_OPT_INDEX:    hopt_d  = obj_data[15:0];
          `METHOD_INDEX:      meth_d  = obj_data[7:0];
          `OPSET_INDEX:       opset_d = obj_data[7:0];
          `NV_WRITE_INDEX: begin
            nvreq_d  = 1'b1;
            nvdone_d = (opset_q == `OPSET_MANUAL) && (meth_q == 8'hFF);
          end
          default:            rej_d   = 1'b1;
        endcase
      end
    end
    // Priority only latched at power-on, so a live NV write changes nothing now
    boot_d   = 1'b0;
    drvpri_d = boot_q ? restored_priority : drvpri_q;
    init_d   = (init_q == '0) ? init_q : init_q - 1'b1;
    remote_d = remote_q | (init_q == '0);
    ilim = forward_limit_sensor | reverse_limit_sensor | forward_motion_prohibit
         | reverse_motion_prohibit | soft_limit | mech_limit;
    sw_d = 16'h0000;
    sw_d[`SW_TLIM_BIT]   = torque_limit_reached;
    sw_d[`SW_ILIM_BIT]   = ilim;
    sw_d[`SW_HERR_BIT]   = code_d[2];
    sw_d[`SW_HATT_BIT]   = code_d[1];
    sw_d[`SW_TREACH_BIT] = code_d[0];
    sw_d[`SW_REMOTE_BIT] = remote_d;
    sw_d[`SW_WARN_BIT]   = info_active;
  end
  // Power-on restart captures the restored priority after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cw_q     <= `CMD_WORD_RESET;
      prev4_q  <= 1'b0;
      homing_q <= 1'b0;
      code_q   <= HS_IDLE;
      start_q  <= 1'b0;
      decel_q  <= 1'b0;
      halt_q   <= 1'b0;
      preset_q <= 1'b0;
      offs_q   <= 32'h0000_0000;
      hopt_q   <= 16'h0000;
      meth_q   <= `METHOD_RESET;
      opset_q  <= 8'h00;
      nvreq_q  <= 1'b0;
      nvdone_q <= 1'b0;
      drvpri_q <= 1'b0;
      rej_q    <= 1'b0;
      sw_q     <= 16'h0000;
      remote_q <= 1'b0;
      init_q   <= INIT_CYCLES[$clog2(INIT_CYCLES+1)-1:0];
      boot_q   <= 1'b1;
    end else begin
      cw_q     <= cw_d;
      prev4_q  <= prev4_d;
      homing_q <= homing_d;
      code_q   <= code_d;
      start_q  <= start_d;
      decel_q  <= decel_d;
      halt_q   <= halt_d;
      preset_q <= preset_d;
      offs_q   <= offs_d;
      hopt_q   <= hopt_d;
      meth_q   <= meth_d;
      opset_q  <= opset_d;
      nvreq_q  <= nvreq_d;
      nvdone_q <= nvdone_d;
      drvpri_q <= drvpri_d;
      rej_q    <= rej_d;
      sw_q     <= sw_d;
      remote_q <= remote_d;
      init_q   <= init_d;
      boot_q   <= boot_d;
    end
  end
  assign drive_status_word  = sw_q;
  assign drive_command_word = cw_q;
  assign obj_reject         = rej_q;
  assign home_start         = start_q;
  assign decel_stop         = decel_q;
  assign halt_stop          = halt_q;
  assign halt_option        = hopt_q;
  assign home_method        = meth_q;
  assign preset_pos         = preset_q;
  assign preset_value       = offs_q;
  assign use_driver_params  = drvpri_q;
  assign nv_write_req       = nvreq_q;
  start_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    home_start |-> $past(homing_q) == 1'b0 && homing_q)
    else $error("start without idle to running step");
  rising_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pdo_update && !start_edge) |=> !home_start)
    else $error("start without rising edge of start bit");
  start_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pdo_update && blocked && !homing_q) |=> !home_start)
    else $error("start taken while blocked");
  method_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pdo_update && !m_valid && !homing_q) |=> !home_start && !preset_pos)
    else $error("start taken with unsupported method");
  preset_done_a: assert property (@(posedge clk) disable iff (!arst_n)
    (homing_q && home_done && !home_alarm) |=> preset_pos && preset_value == $past(offs_q))
    else $error("no preset on completion");
  preset_method_a: assert property (@(posedge clk) disable iff (!arst_n)
    (pdo_update && start_edge && !blocked && m_valid && m_preset) |=> preset_pos && !home_start)
    else $error("home preset method did not preset at once");
  decel_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (homing_q && !home_done && !home_alarm && !cw_q[`CW_START_BIT]) |=> decel_stop)
    else $error("no stop on start clear");
  halt_abort_a: assert property (@(posedge clk) disable iff (!arst_n)
    (homing_q && !home_done && !home_alarm && cw_q[`CW_HALT_BIT]) |=> decel_stop && !homing_q)
    else $error("halt did not stop homing");
  halt_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 halt_stop == $past(cw_q[`CW_HALT_BIT]))
    else $error("halt stop mismatch");
  torque_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 drive_status_word[`SW_TLIM_BIT] == $past(torque_limit_reached))
    else $error("torque flag mismatch");
  ilim_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 drive_status_word[`SW_ILIM_BIT] == $past(ilim))
    else $error("internal limit flag mismatch");
  code_legal_a: assert property (@(posedge clk) disable iff (!arst_n)
    {sw_q[`SW_HERR_BIT], sw_q[`SW_HATT_BIT]} != 2'b11
    && {sw_q[`SW_HERR_BIT], sw_q[`SW_HATT_BIT], sw_q[`SW_TREACH_BIT]} != 3'b010
    && {sw_q[`SW_HERR_BIT], sw_q[`SW_HATT_BIT], sw_q[`SW_TREACH_BIT]} != 3'b100)
    else $error("illegal homing code");
  code_alarm_a: assert property (@(posedge clk) disable iff (!arst_n)
    (homing_q && home_alarm) |=> {sw_q[`SW_HERR_BIT], sw_q[`SW_HATT_BIT], sw_q[`SW_TREACH_BIT]} == 3'b101)
    else $error("alarm code not reported");
  warn_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(info_active) |=> !drive_status_word[`SW_WARN_BIT])
    else $error("warning not auto cleared");
  warn_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    info_active |=> drive_status_word[`SW_WARN_BIT])
    else $error("warning not raised");
  sensor_rej_a: assert property (@(posedge clk) disable iff (!arst_n)
    (obj_wr && sensor_param_wr) |=> obj_reject && $stable(offs_q))
    else $error("sensor parameter overwritten");
  remote_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    remote_q |=> remote_q)
    else $error("remote dropped");
  remote_late_a: assert property (@(posedge clk) disable iff (!arst_n)
    (init_q != '0 && !remote_q) |=> !remote_q)
    else $error("remote raised before initialization ended");
  prio_fixed_a: assert property (@(posedge clk) disable iff (!arst_n)
    !boot_q |=> $stable(drvpri_q))
    else $error("parameter priority changed after start-up");
endmodule // homing_ctrl
`default_nettype wire

// >>> logic/homing_defines.svh
// Constants for the homing-mode control and status block.
// Assumes inclusion by bare name from logic/ and tb/ files.
`ifndef HOMING_DEFINES_SVH
`define HOMING_DEFINES_SVH
`define CMD_WORD_INDEX     16'h6040
`define STAT_WORD_INDEX    16'h6041
`define HOME_OFFSET_INDEX  16'h607C
`define HALT_OPT_INDEX     16'h605D
`define METHOD_INDEX       16'h6098
`define OPSET_INDEX        16'h47F5
`define NV_WRITE_INDEX     16'h40C9
`define CW_START_BIT       4
`define CW_HALT_BIT        8
`define SW_WARN_BIT        7
`define SW_REMOTE_BIT      9
`define SW_TREACH_BIT      10
`define SW_ILIM_BIT        11
`define SW_HATT_BIT        12
`define SW_HERR_BIT        13
`define SW_TLIM_BIT        15
`define CMD_WORD_RESET     16'h0000
`define METHOD_RESET       8'h18
`define OPSET_MANUAL       8'h01
`define INIT_TIME_US       10
`define INIT_CYCLES        ((`INIT_TIME_US * 1000) / 25)
`endif

// >>> logic/homing_pkg.sv
// Types shared by the homing-mode block.
// Assumes homing_defines.svh is on the include path.
package homing_pkg;
  typedef enum logic [2:0] {
    HS_RUNNING   = 3'b000,
    HS_IDLE      = 3'b001,
    HS_DONE      = 3'b011,
    HS_ALARM     = 3'b101
  } home_code_t;
  typedef enum logic [1:0] {
    PS_NONE,
    PS_LOADED,
    PS_PRIORITY
  } param_src_t;
endpackage

// >>> logic/method_check.sv
// Homing method validity decode.
// Assumes an 8-bit signed method code.
`timescale 1ns/10ps
`default_nettype none
module method_check (
  // Method code
  input  wire logic [7:0] method,
  // Decode
  output logic            valid,
  output logic            preset_only
);
  always_comb begin
    unique case (method)
      8'h11, 8'h12, 8'h18, 8'h1C, 8'hFF: begin
        valid       = 1'b1;
        preset_only = 1'b0;
      end
      8'h23, 8'h25: begin
        valid       = 1'b1;
        preset_only = 1'b1;
      end
      default: begin
        valid       = 1'b0;
        preset_only = 1'b0;
      end
    endcase
  end
endmodule // method_check
`default_nettype wire

// >>> logic/pin_sync.sv
// Three-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;
  always_comb begin
    sh_d  = {sh_q[1:0], pin};
    lvl_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : lvl_q;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q  <= 3'b000;
      lvl_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end
  assign level = lvl_q;
endmodule // pin_sync
`default_nettype wire

// >>> tb/fieldbus_master.sv
// Fieldbus master model: writes the command word and objects.
// Assumes the block's clk; drives only just after rising edges.
`timescale 1ns/10ps
`default_nettype none
`include "homing_defines.svh"
module fieldbus_master (
  // Clock
  input  wire logic        clk,
  // Process data
  output logic             pdo_update,
  output logic      [15:0] cmd_word_in,
  // Object writes
  output logic             obj_wr,
  output logic      [15:0] obj_index,
  output logic      [31:0] obj_data
);
  initial begin
    {pdo_update, obj_wr} = '0;
    cmd_word_in = 16'h0000;
    obj_index = 16'h0000;
    obj_data = 32'h0000_0000;
  end
  // Two updates per word, so the previous copy catches up
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    pdo_update <= 1'b1;
    cmd_word_in <= w;
    repeat (2) @(posedge clk);
    pdo_update <= 1'b0;
  endtask
  // Released bus shows inverted data, never the last value
  task automatic wr_obj(input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    obj_wr <= 1'b1;
    obj_index <= idx;
    obj_data <= d;
    @(posedge clk);
    obj_wr <= 1'b0;
    obj_index <= ~idx;
    obj_data <= ~d;
  endtask
  // Manual setting, method -1, then batch store
  task automatic prio_setup();
    wr_obj(`OPSET_INDEX, 32'h0000_0001);
    wr_obj(`METHOD_INDEX, 32'h0000_00FF);
    wr_obj(`NV_WRITE_INDEX, 32'h0000_0001);
  endtask
endmodule // fieldbus_master
`default_nettype wire

// >>> tb/tb_top.sv
// Bench for the homing control block: flags, start rules, codes, objects.
// Assumes homing_defines.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "homing_defines.svh"
module tb_top;
  logic        clk, arst_n, pdo_update, obj_wr, obj_reject, op_enabled, motor_excited;
  logic        stop_pin, sensor_param_wr, torque_limit_reached, info_active, restored_priority;
  logic        motion_busy, home_done, home_alarm, home_start, decel_stop, halt_stop;
  logic        preset_pos, use_driver_params, nv_write_req;
  logic [5:0]  lim;
  logic [7:0]  home_method;
  logic [15:0] cmd_word_in, drive_status_word, drive_command_word, obj_index, halt_option;
  logic [31:0] obj_data, preset_value;
  logic [7:0]  meth [7] = '{8'h11, 8'h12, 8'h18, 8'h1C, 8'h23, 8'h25, 8'hFF};
  int          err_count, compares, n_st, n_dc, n_pr, n_rj, n_nv;

  fieldbus_master m (.clk, .pdo_update, .cmd_word_in, .obj_wr, .obj_index, .obj_data);
  homing_ctrl #(.INIT_CYCLES(4)) uut (
    .clk, .arst_n, .pdo_update, .cmd_word_in, .drive_status_word, .drive_command_word,
    .obj_wr, .obj_index, .obj_data, .obj_reject, .op_enabled, .motor_excited, .stop_pin,
    .sensor_param_wr, .torque_limit_reached, .forward_limit_sensor(lim[0]),
    .reverse_limit_sensor(lim[1]), .forward_motion_prohibit(lim[2]),
    .reverse_motion_prohibit(lim[3]), .soft_limit(lim[4]), .mech_limit(lim[5]),
    .info_active, .restored_priority, .motion_busy, .home_done, .home_alarm, .home_start,
    .decel_stop, .halt_stop, .halt_option, .home_method, .preset_pos, .preset_value,
    .use_driver_params, .nv_write_req
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulse counters, so checks need not hit the exact cycle
  always @(posedge clk) begin
    if (home_start === 1'b1) n_st++;
    if (decel_stop === 1'b1) n_dc++;
    if (preset_pos === 1'b1) n_pr++;
    if (obj_reject === 1'b1) n_rj++;
    if (nv_write_req === 1'b1) n_nv++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [2:0] code();
    return {drive_status_word[13], drive_status_word[12], drive_status_word[10]};
  endfunction
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start_home();
    m.send(16'h0000);
    m.send(16'h0010);
    wt(3);
  endtask
  task automatic pulse_done(input bit alarm);
    @(posedge clk);
    home_alarm <= alarm;
    home_done <= !alarm;
    @(posedge clk);
    {home_done, home_alarm} <= 2'b00;
    wt(3);
  endtask

  initial begin
    wt(20000);
    err_count++;
    summarize();
  end
  initial begin
    arst_n = 1'b0;
    {op_enabled, motor_excited} = 2'b11;
    {motion_busy, home_done, home_alarm, stop_pin, sensor_param_wr} = '0;
    {torque_limit_reached, info_active, restored_priority} = '0;
    lim = 6'h00;
    wt(10);
    arst_n <= 1'b1;
    wt(2);
    chk("code idle", 3'b001, code());
    chk("cmd word", `CMD_WORD_RESET, drive_command_word);
    chk("prio", 1'b0, use_driver_params);
    for (int i = 0; i < 50 && drive_status_word[9] !== 1'b1; i++) wt(1);
    chk("remote", 16'h0600, drive_status_word);
    $display("Test reset done");
    for (int k = 0; k < 4; k++) begin
      torque_limit_reached <= k[0];
      info_active <= k[1];
      wt(2);
      chk("torque info", 16'h0600 | {k[0], 15'h0000} | {8'h00, k[1], 7'h00}, drive_status_word);
    end
    torque_limit_reached <= 1'b0;
    info_active <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      lim <= 6'h01 << k;
      wt(2);
      chk("limit", 1'b1, drive_status_word[11]);
    end
    lim <= 6'h00;
    wt(2);
    chk("flags off", 16'h0600, drive_status_word);
    $display("Test flags done");
    for (int k = 0; k < 5; k++) begin
      motion_busy <= (k == 0);
      stop_pin <= (k == 2);
      op_enabled <= (k != 3);
      motor_excited <= (k != 4);
      wt(6);
      m.send(16'h0000);
      m.send(k == 1 ? 16'h0110 : 16'h0010);
      wt(4);
      chk("blocked", 0, n_st);
      if (k == 1) chk("halt", 1'b1, halt_stop);
    end
    {op_enabled, motor_excited} <= 2'b11;
    m.wr_obj(`HOME_OFFSET_INDEX, 32'h1234_5678);
    m.wr_obj(`HALT_OPT_INDEX, 32'h0000_0002);
    wt(2);
    chk("halt opt", 16'h0002, halt_option);
    $display("Test blocking done");
    start_home();
    chk("halt off", 1'b0, halt_stop);
    chk("start", 1, n_st);
    chk("code run", 3'b000, code());
    pulse_done(1'b0);
    chk("preset", 1, n_pr);
    chk("preset val", 32'h1234_5678, preset_value);
    chk("code done", 3'b011, code());
    m.send(16'h0010);
    wt(3);
    chk("steady", 1, n_st);
    start_home();
    m.send(16'h0000);
    wt(3);
    chk("decel", 1, n_dc);
    chk("code stop", 3'b001, code());
    start_home();
    pulse_done(1'b1);
    chk("code alarm", 3'b101, code());
    start_home();
    m.send(16'h0110);
    wt(3);
    chk("halt stop", 3'b001, code());
    chk("starts", 4, n_st);
    m.wr_obj(`METHOD_INDEX, 32'h0000_0005);
    start_home();
    chk("bad method", 4, n_st);
    m.wr_obj(`METHOD_INDEX, 32'h0000_0025);
    start_home();
    chk("preset method", 2, n_pr);
    chk("preset starts", 4, n_st);
    chk("code preset", 3'b011, code());
    $display("Test homing done");
    foreach (meth[i]) begin
      m.wr_obj(`METHOD_INDEX, {24'h00_0000, meth[i]});
      wt(1);
      chk("method", meth[i], home_method);
    end
    chk("no reject", 0, n_rj);
    sensor_param_wr <= 1'b1;
    m.wr_obj(`HOME_OFFSET_INDEX, 32'h0000_0001);
    sensor_param_wr <= 1'b0;
    m.wr_obj(16'h1234, 32'h0000_0001);
    wt(2);
    chk("reject", 2, n_rj);
    m.prio_setup();
    wt(2);
    chk("nv write", 1, n_nv);
    restored_priority <= 1'b1;
    arst_n <= 1'b0;
    wt(2);
    arst_n <= 1'b1;
    wt(2);
    chk("prio", 1'b1, use_driver_params);
    chk("code reset", 3'b001, code());
    $display("Test objects done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
